// File: bench/ofm_contactor.sv
// contactor feedback model for monitor 0
module ofm_contactor (
  // clock, output level and fault command
  input  wire logic core_clk,
  input  wire logic cycle_tick,
  input  wire logic level,
  input  wire logic stuck,
  output logic      fb
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] d = 2'h3;
  initial fb = 1'h1;
  // slow contact: opposite level three ticks late, frozen when stuck
  always @(posedge core_clk) if (cycle_tick && !stuck) begin
    d  <= {d[0], ~level};
    fb <= d[1];
  end
endmodule

// File: bench/ofm_props.sv
// assertion checker for the monitor block ports
module ofm_props #(
  parameter int NUM_MON  = 32,
  parameter int NUM_LOOP = 8
) (
  // clock and tick
  input wire logic                core_clk,
  input wire logic                resetn,
  input wire logic                cycle_tick,
  // monitor and loop pins
  input wire logic [NUM_MON-1:0]  safety_out_level,
  input wire logic [NUM_MON-1:0]  clear_in,
  input wire logic [NUM_MON-1:0]  mon_out,
  input wire logic [NUM_MON-1:0]  error_out,
  input wire logic [NUM_MON-1:0]  clear_lamp,
  input wire logic [NUM_LOOP-1:0] loop_feedback_out,
  input wire logic [NUM_LOOP-1:0] loop_feedback_in
);
  // *****
  // properties
  // *****
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_GATE: assert property ((mon_out & ~safety_out_level) == '0)
    else $error("output high while level low");
  AST_ERR: assert property ((error_out & mon_out) == '0)
    else $error("error with output high");
  AST_LAMP: assert property ((clear_lamp & mon_out) == '0)
    else $error("lamp with output high");
  AST_LOOP: assert property (cycle_tick |=> loop_feedback_in == $past(loop_feedback_out))
    else $error("loop input missed");
  AST_LOOP_HOLD: assert property (!cycle_tick |=> $stable(loop_feedback_in))
    else $error("loop moved off tick");
  AST_LAMP_TICK: assert property (!cycle_tick |=> $stable(clear_lamp))
    else $error("lamp moved off tick");
  AST_ERR_TICK: assert property (!cycle_tick |=> (~mon_out & $past(mon_out) & safety_out_level & $past(safety_out_level)) == '0)
    else $error("fault rose off tick");
  AST_CLEAR: assert property (cycle_tick |=> (error_out & $past(clear_in)) == '0)
    else $error("clear ignored");
endmodule
bind ofm_top ofm_props #(.NUM_MON(NUM_MON), .NUM_LOOP(NUM_LOOP)) chk_u (
  .core_clk          (core_clk),
  .resetn            (resetn),
  .cycle_tick        (cycle_tick),
  .safety_out_level  (safety_out_level),
  .clear_in          (clear_in),
  .mon_out           (mon_out),
  .error_out         (error_out),
  .clear_lamp        (clear_lamp),
  .loop_feedback_out (loop_feedback_out),
  .loop_feedback_in  (loop_feedback_in)
);

// File: bench/tb_top.sv
// self-checking bench for the output feedback monitor
`include "ofm_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ofm_pkg::*;
  // *****
  // bench
  // *****
  logic        core_clk = 0, resetn = 0, tick = 0, stuck = 0, fb, rdn = 0, wrn = 0, wq, irq;
  logic [31:0] lvl = 0, clr = 0, mout, eout, lamp;
  logic [7:0]  lfo = 0, lfi, tin = 0, tbus;
  logic [1:0]  tc = 0;
  logic [15:0] lf = 16'h9d6c;
  ofm_addr_t   adr = 0;
  ofm_word_t   wd = 0, rd, q[$];
  int          errors = 0, comparisons = 0;
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    tc   <= tc + 2'h1;
    tick <= tc == 2'h0;
  end
  ofm_contactor cnt_u (.core_clk, .cycle_tick(tick), .level(lvl[0]), .stuck, .fb);
  ofm_top dut_u (.core_clk, .resetn, .cycle_tick(tick), .mon_enable_in('1), .safety_out_level(lvl),
    .feedback_in({~lvl[31:1], fb}), .clear_in(clr), .mon_out(mout), .error_out(eout), .clear_lamp(lamp),
    .loop_feedback_out(lfo), .loop_feedback_in(lfi), .term_in(tin), .term_bus(tbus), .avs_address(adr),
    .avs_read(rdn), .avs_write(wrn), .avs_writedata(wd), .avs_readdata(rd), .avs_waitrequest(wq), .irq);
  function automatic logic [15:0] nxt(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic ofm_addr_t ra(logic [3:0] i);
    return {2'h0, i, 2'h0};
  endfunction
  task automatic chk(logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic bus(logic w, ofm_addr_t a, ofm_word_t d);
    @(posedge core_clk);
    adr <= a;
    wd  <= d;
    rdn <= !w;
    wrn <= w;
    do @(posedge core_clk); while (wq);
    rdn <= 0;
    wrn <= 0;
    @(negedge core_clk);
  endtask
  task automatic rdx(ofm_addr_t a, ofm_word_t e);
    q.push_back(e);
    bus(0, a, 0);
  endtask
  task automatic run(int n);
    repeat (4 * n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic finish_test;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge core_clk) if (rdn && !wq) chk(rd, q.pop_front());
  initial begin
    #100000;
    errors++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1;
    rdx(ra(`OFM_REG_CTRL), 32'h0000_0003);
    rdx(ra(`OFM_REG_WINDOW), 32'h0000_0032);
    rdx(8'h1c, 32'h0000_0000);
    bus(1, ra(`OFM_REG_WINDOW), 32'h0000_0008);
    bus(1, ra(`OFM_REG_IRQ_MASK), 32'h0000_0001);
    $display("test registers done");
    @(posedge core_clk) lvl <= 32'h0000_0001;
    run(16);
    chk(mout, lvl);
    chk(eout, 0);
    @(posedge core_clk) lvl <= 32'h0000_0000;
    run(16);
    rdx(ra(`OFM_REG_STATUS), 0);
    $display("test good feedback done");
    @(posedge core_clk) stuck <= 1;
    @(posedge core_clk) lvl <= 32'h0000_0001;
    run(16);
    chk(mout, 0);
    chk(eout, 1);
    rdx(ra(`OFM_REG_STATUS), 1);
    @(posedge core_clk) stuck <= 0;
    run(6);
    chk(eout, 1);
    bus(1, ra(`OFM_REG_CTRL), 32'h0000_0001);
    chk(eout, 0);
    bus(1, ra(`OFM_REG_CTRL), 32'h0000_0003);
    chk(eout, 1);
    chk(irq, 1);
    bus(1, ra(`OFM_REG_IRQ_MASK), 0);
    chk(irq, 0);
    bus(1, ra(`OFM_REG_IRQ_MASK), 1);
    chk(irq, 1);
    @(posedge core_clk) clr <= 32'h0000_0001;
    run(2);
    chk(eout, 0);
    chk(mout, lvl);
    @(posedge core_clk) clr <= 0;
    bus(1, ra(`OFM_REG_IRQ_STAT), 32'h0000_0003);
    chk(irq, 0);
    $display("test fault and clear done");
    repeat (3) begin
      lf = nxt(lf);
      @(posedge core_clk) {lfo, tin} <= lf;
      run(2);
      chk(lfi, lfo);
      chk(tbus, tin);
      rdx(ra(`OFM_REG_TERM), tin);
    end
    $display("test loops done");
    finish_test();
  end
endmodule

// File: logic/ofm_consts.svh
// constants for the output feedback monitor block
`ifndef OFM_CONSTS_SVH
`define OFM_CONSTS_SVH

// ****************************************************************
// register offsets (word indexes, byte address is index times 4)
// ****************************************************************
`define OFM_REG_CTRL      4'h0
`define OFM_REG_WINDOW    4'h1
`define OFM_REG_STATUS    4'h2
`define OFM_REG_IRQ_STAT  4'h3
`define OFM_REG_IRQ_MASK  4'h4
`define OFM_REG_LOOP      4'h5
`define OFM_REG_TERM      4'h6

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define OFM_CTRL_CLEAR_EN   0
`define OFM_CTRL_ERROR_EN   1
`define OFM_IRQ_FAULT       0
`define OFM_IRQ_CLEARED     1
`define OFM_WINDOW_RESET    16'h0032
`define OFM_FLASH_HALF      8'h10
`define OFM_ADDR_LSB        2
`define OFM_ADDR_W          4

`endif

// File: logic/ofm_pkg.sv
// types for the output feedback monitor block
package ofm_pkg;
  typedef logic [31:0] ofm_word_t;
  typedef logic [7:0]  ofm_addr_t;
endpackage

// File: logic/ofm_top.sv
// output feedback monitor, internal loop and terminator blocks with avalon register slave
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`include "ofm_consts.svh"

// ****************************************************************
// top module
// ****************************************************************
// Overview of operation
// - up to 32 monitor instances supported
// - timeout drives output low, flashes clear lamp
// - error output high on timeout when enabled
// - window length is configurable, one window shared by all monitors
// - clear input at one clears latched error
// - loop input follows loop output one cycle later
// - up to 8 loop pairs supported
// - terminated inputs still reported to bus
module ofm_top #(
  parameter int NUM_MON  = 32,
  parameter int NUM_LOOP = 8,
  parameter int NUM_TERM = 8,
  parameter int WIN_W    = 16
) (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  // logic cycle tick
  input  wire logic                     cycle_tick,
  // monitor side
  input  wire logic [NUM_MON-1:0]       mon_enable_in,
  input  wire logic [NUM_MON-1:0]       safety_out_level,
  input  wire logic [NUM_MON-1:0]       feedback_in,
  input  wire logic [NUM_MON-1:0]       clear_in,
  output logic      [NUM_MON-1:0]       mon_out,
  output logic      [NUM_MON-1:0]       error_out,
  output logic      [NUM_MON-1:0]       clear_lamp,
  // internal feedback loops
  input  wire logic [NUM_LOOP-1:0]      loop_feedback_out,
  output logic      [NUM_LOOP-1:0]      loop_feedback_in,
  // terminated inputs
  input  wire logic [NUM_TERM-1:0]      term_in,
  output logic      [NUM_TERM-1:0]      term_bus,
  // avalon-mm slave
  input  wire ofm_pkg::ofm_addr_t       avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire ofm_pkg::ofm_word_t       avs_writedata,
  output ofm_pkg::ofm_word_t            avs_readdata,
  output logic                          avs_waitrequest,
  output logic                          irq
);
  import ofm_pkg::*;

  localparam int MI = $clog2(NUM_MON);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [1:0] {
    OFM_BUS_IDLE = 2'b01,
    OFM_BUS_DONE = 2'b10
  } ofm_bus_t;

  typedef struct packed {
    ofm_bus_t                         bus;
    ofm_word_t                        rdata;
    logic                             clear_en;
    logic                             error_en;
    logic [WIN_W-1:0]                 window;
    logic [1:0]                       irq_stat;
    logic [1:0]                       irq_mask;
    logic [NUM_MON-1:0]               last_out;
    logic [NUM_MON-1:0]               fault;
    logic [NUM_MON-1:0][WIN_W-1:0]    timer;
    logic [NUM_LOOP-1:0]              loop;
    logic [NUM_TERM-1:0]              term;
    logic [7:0]                       flash_cnt;
    logic                             flash;
  } ofm_state_t;

  ofm_state_t st;
  ofm_state_t next_st;

  // decode a word offset from the byte address
  function automatic logic [`OFM_ADDR_W-1:0] reg_index(input ofm_addr_t a);
    reg_index = a[`OFM_ADDR_LSB +: `OFM_ADDR_W];
  endfunction

  logic wr_hit;
  logic [`OFM_ADDR_W-1:0] idx;
  assign idx    = reg_index(avs_address);
  // a write lands only at the edge where waitrequest is seen low
  assign wr_hit = avs_write && st.bus == OFM_BUS_DONE;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [1:0] ev;
    next_st = st;
    ev      = 2'b00;
    // lamp flashing divider, one step per logic cycle
    if (cycle_tick) begin
      if (st.flash_cnt == `OFM_FLASH_HALF) begin
        next_st.flash_cnt = '0;
        next_st.flash     = !st.flash;
      end else begin
        next_st.flash_cnt = st.flash_cnt + 8'h01;
      end
    end
    for (int i = 0; i < NUM_MON; i++) begin
      if (cycle_tick) begin
        next_st.last_out[i] = safety_out_level[i];
        if (!mon_enable_in[i]) begin
          next_st.timer[i] = '0;
          next_st.fault[i] = 1'b0;
        end else if (safety_out_level[i] != st.last_out[i]) begin
          next_st.timer[i] = '0;
        end else if (feedback_in[i] == safety_out_level[i]) begin
          if (st.timer[i] >= st.window) begin
            if (!st.fault[i]) ev[`OFM_IRQ_FAULT] = 1'b1;
            next_st.fault[i] = 1'b1;
          end else begin
            next_st.timer[i] = st.timer[i] + 1'b1;
          end
        end
        if (st.clear_en && clear_in[i] && st.fault[i]) begin
          next_st.fault[i] = 1'b0;
          next_st.timer[i] = '0;
          ev[`OFM_IRQ_CLEARED] = 1'b1;
        end
      end
    end
    for (int j = 0; j < NUM_LOOP; j++) begin
      if (cycle_tick) next_st.loop[j] = loop_feedback_out[j];
    end
    if (cycle_tick) next_st.term = term_in;
    // register bus: one wait cycle per access
    next_st.bus = OFM_BUS_IDLE;
    if ((avs_read || avs_write) && st.bus == OFM_BUS_IDLE) begin
      next_st.bus   = OFM_BUS_DONE;
      next_st.rdata = '0;
      if (avs_read) begin
        unique case (idx)
          `OFM_REG_CTRL:     next_st.rdata = {30'h0000_0000, st.error_en, st.clear_en};
          `OFM_REG_WINDOW:   next_st.rdata = {{(32-WIN_W){1'b0}}, st.window};
          `OFM_REG_STATUS:   next_st.rdata = 32'(st.fault);
          `OFM_REG_IRQ_STAT: next_st.rdata = {30'h0000_0000, st.irq_stat};
          `OFM_REG_IRQ_MASK: next_st.rdata = {30'h0000_0000, st.irq_mask};
          `OFM_REG_LOOP:     next_st.rdata = 32'(st.loop);
          `OFM_REG_TERM:     next_st.rdata = 32'(st.term);
          default:           next_st.rdata = '0;
        endcase
      end
    end
    if (wr_hit) begin
      unique case (idx)
        `OFM_REG_CTRL: begin
          next_st.clear_en = avs_writedata[`OFM_CTRL_CLEAR_EN];
          next_st.error_en = avs_writedata[`OFM_CTRL_ERROR_EN];
        end
        `OFM_REG_WINDOW:   next_st.window   = avs_writedata[WIN_W-1:0];
        `OFM_REG_IRQ_STAT: next_st.irq_stat = st.irq_stat & ~avs_writedata[1:0];
        `OFM_REG_IRQ_MASK: next_st.irq_mask = avs_writedata[1:0];
        default: ;
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_st.irq_stat = next_st.irq_stat | ev;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st          <= '0;
      st.bus      <= OFM_BUS_IDLE;
      st.window   <= `OFM_WINDOW_RESET;
      st.clear_en <= 1'b1;
      st.error_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign mon_out          = safety_out_level & ~st.fault;
  assign clear_lamp       = st.fault & {NUM_MON{st.flash}};
  assign error_out        = st.fault & {NUM_MON{st.error_en}};
  assign loop_feedback_in = st.loop;
  assign term_bus         = st.term;
  assign avs_readdata     = st.rdata;
  assign avs_waitrequest  = (avs_read || avs_write) && st.bus == OFM_BUS_IDLE;
  assign irq              = |(st.irq_stat & st.irq_mask);
endmodule
